// ### pkg/esl_defines.vh
// Constants for the setup store and loader
`ifndef ESL_DEFINES_VH
`define ESL_DEFINES_VH
`define ESL_EE_BYTES    12'h0800
`define ESL_SP_BASE     16'h0E10
`define ESL_SP_DEPTH    64
`define ESL_SP_AW       6
`define ESL_OP_IOUPD    8'h80
`define ESL_OP_CAL      8'h0A
`define ESL_OP_NULL     8'hB0
`define ESL_OP_CONDMAX  8'hCF
`define ESL_OP_PAUSE    8'hFE
`define ESL_OP_END      8'hFF
`define ESL_PORT_CFG    16'h0000
`define ESL_PIN_EN      16'h0200
`define ESL_PIN_EN_VAL  8'h01
`define ESL_PIN_F_LO    16'h0201
`define ESL_PIN_F_HI    16'h0208
`define ESL_K_WRITE     2'h0
`define ESL_K_IOUPD     2'h1
`define ESL_K_CAL       2'h2
`define ESL_K_SYNC      2'h3
`define ESL_PU_WAIT     2'h3
`endif

// ### design/esl_loader.v
// Setup store and loader: scratch pad, EEPROM array, upload/download engine, output FIFO
// Function
// - Pause ends segment, end halts sequence
// - Upload trigger appends scratch pad to EEPROM
// - Register condition plus trigger starts download
// - Power-up runs download with pin condition
// - EEPROM addressing limited to 2048 bytes
// - Non-data instructions take one byte
// - Data instruction stored as N+4 bytes
// - Byte 0x80 decodes as I/O update
// - Data byte is count minus one, address high-first
// - Otherwise one sync pulse issued before the first pin load of a download
// - Scratch pad starts at offset 0x0E10
// - Port config register never read or written
// - Nonzero register condition overrides pin latch
// - Skip instructions tagged only for other conditions under nonzero condition
// - B0 clears the condition tag board
// - Download busy held until download ends and output FIFO drains
`timescale 1ns/100ps
`include "esl_defines.vh"

// =====================================================================
// FIFO
module esl_fifo #(
  parameter W = 26,
  parameter D = 4
) (
  input  wire         clock,
  input  wire         reset,
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);
  localparam AW = (D > 1) ? $clog2(D) : 1;
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0]   cnt_r;
  wire         push = in_valid & in_ready;
  wire         pop  = out_valid & out_ready;
  assign in_ready  = (cnt_r != D[AW:0]);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data  = mem[rp_r];
  always @(posedge clock) begin
    if (push)
      mem[wp_r] <= in_data;
  end
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      wp_r  <= {AW{1'b0}};
      rp_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wp_r <= (wp_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
      if (pop)
        rp_r <= (rp_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
      if (push & ~pop)
        cnt_r <= cnt_r + 1'b1;
      else if (pop & ~push)
        cnt_r <= cnt_r - 1'b1;
    end
  end
endmodule

// =====================================================================
// Loader
module esl_loader #(
  parameter FIFO_DEPTH = 4
) (
  input  wire        clock,
  input  wire        reset,
  input  wire        sp_wr_en,
  input  wire [15:0] sp_wr_addr,
  input  wire [7:0]  sp_wr_data,
  input  wire        upload_start,
  input  wire        download_start,
  input  wire [3:0]  cond_reg,
  input  wire [1:0]  cfg_select_pin_low,
  input  wire [1:0]  cfg_select_pin_high,
  output reg  [15:0] reg_rd_addr,
  input  wire [7:0]  reg_rd_data,
  output wire        cfg_wr_valid,
  input  wire        cfg_wr_ready,
  output wire [1:0]  cfg_wr_kind,
  output wire [15:0] cfg_wr_addr,
  output wire [7:0]  cfg_wr_data,
  output wire        upload_busy,
  output wire        download_busy,
  output reg         upload_overflow,
  output reg         checksum_error,
  output reg  [11:0] ee_used,
  output reg  [3:0]  powerup_condition_latch
);
  localparam S_IDLE = 11'h001;
  localparam S_UFET = 11'h002;
  localparam S_UAH  = 11'h004;
  localparam S_UAL  = 11'h008;
  localparam S_UDAT = 11'h010;
  localparam S_USUM = 11'h020;
  localparam S_DFET = 11'h040;
  localparam S_DAH  = 11'h080;
  localparam S_DAL  = 11'h100;
  localparam S_DDAT = 11'h200;
  localparam S_DSUM = 11'h400;

  // Three-level pins: 0 low, 1 open, 2 high; open/open bypasses the store
  function [3:0] pin_cond;
    input [1:0] hi;
    input [1:0] lo;
    reg   [3:0] id;
    begin
      id = {2'b00, hi} * 4'd3 + {2'b00, lo};
      case (id)
        4'd4:    pin_cond = 4'd0;
        4'd0,
        4'd1,
        4'd2,
        4'd3:    pin_cond = id + 4'd1;
        default: pin_cond = (id > 4'd8) ? 4'd0 : id;
      endcase
    end
  endfunction

  reg  [7:0]  ee_mem [0:2047];
  reg  [7:0]  sp_mem [0:`ESL_SP_DEPTH-1];
  reg  [10:0] state_r;
  reg  [`ESL_SP_AW:0] sp_ptr_r;
  reg  [11:0] rp_r;
  reg  [7:0]  cnt_r;
  reg  [7:0]  sum_r;
  reg  [7:0]  ahi_r;
  reg  [15:0] wa_r;
  reg  [31:0] board_r;
  reg  [3:0]  cond_r;
  reg         exec_r;
  reg         pin_en_seen_r;
  reg         pin_armed_r;
  reg         sync_sent_r;
  reg  [1:0]  plo_s1_r;
  reg  [1:0]  plo_s2_r;
  reg  [1:0]  phi_s1_r;
  reg  [1:0]  phi_s2_r;
  reg  [1:0]  pu_cnt_r;
  reg         pu_done_r;
  reg         ee_we;
  reg  [7:0]  ee_wd;
  reg         f_valid;
  reg  [25:0] f_data;
  wire        f_ready;
  wire [7:0]  sp_b = sp_mem[sp_ptr_r[`ESL_SP_AW-1:0]];
  wire [7:0]  ee_b = ee_mem[rp_r[10:0]];
  wire [15:0] sp_off = sp_wr_addr - `ESL_SP_BASE;
  // Condition opcodes count up from the null opcode, so the first one tags entry 1
  wire [7:0]  tag_idx = ee_b - `ESL_OP_NULL;
  wire        sp_end = (sp_ptr_r == `ESL_SP_DEPTH);
  wire        ee_full = (ee_used == `ESL_EE_BYTES);
  wire        ee_eof = (rp_r == `ESL_EE_BYTES);
  wire [3:0]  eff_cond = (cond_reg != 4'd0) ? cond_reg : powerup_condition_latch;
  wire        is_cond = (ee_b >= `ESL_OP_NULL) && (ee_b <= `ESL_OP_CONDMAX);
  wire        is_data = (ee_b < `ESL_OP_IOUPD) && (ee_b != `ESL_OP_CAL);
  // Tag board gates execution only while something is tagged
  wire        exec = (cond_r == 4'd0) || (board_r == 32'h0000_0000)
                     || board_r[cond_r];
  wire        pin_func = (wa_r >= `ESL_PIN_F_LO) && (wa_r <= `ESL_PIN_F_HI);
  wire        need_sync = pin_func && !pin_armed_r && !sync_sent_r;
  wire        dl_pu = pu_cnt_r == `ESL_PU_WAIT && !pu_done_r
                      && pin_cond(phi_s2_r, plo_s2_r) != 4'd0;

  assign upload_busy   = (state_r[5:1] != 5'b00000);
  assign download_busy = (state_r[10:6] != 5'b00000) || cfg_wr_valid;

  // =====================================================================
  // Scratch pad and power-up pin capture
  always @(posedge clock) begin
    if (sp_wr_en && sp_wr_addr >= `ESL_SP_BASE
        && sp_wr_addr < `ESL_SP_BASE + `ESL_SP_DEPTH)
      sp_mem[sp_off[`ESL_SP_AW-1:0]] <= sp_wr_data;
    if (ee_we)
      ee_mem[ee_used[10:0]] <= ee_wd;
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      plo_s1_r <= 2'h0;
      plo_s2_r <= 2'h0;
      phi_s1_r <= 2'h0;
      phi_s2_r <= 2'h0;
      pu_cnt_r <= 2'h0;
      pu_done_r <= 1'b0;
      powerup_condition_latch <= 4'h0;
    end else begin
      plo_s1_r <= cfg_select_pin_low;
      plo_s2_r <= plo_s1_r;
      phi_s1_r <= cfg_select_pin_high;
      phi_s2_r <= phi_s1_r;
      if (pu_cnt_r != `ESL_PU_WAIT)
        pu_cnt_r <= pu_cnt_r + 2'h1;
      else if (!pu_done_r) begin
        pu_done_r <= 1'b1;
        powerup_condition_latch <= pin_cond(phi_s2_r, plo_s2_r);
      end
    end
  end

  // =====================================================================
  // EEPROM write and FIFO push steering
  always @* begin
    ee_we   = 1'b0;
    ee_wd   = 8'h00;
    f_valid = 1'b0;
    f_data  = {`ESL_K_WRITE, wa_r, ee_b};
    case (state_r)
      S_UFET, S_UAH, S_UAL: begin
        ee_we = !sp_end && !ee_full;
        ee_wd = sp_b;
      end
      S_UDAT: begin
        ee_we = !ee_full;
        ee_wd = (reg_rd_addr == `ESL_PORT_CFG) ? 8'h00 : reg_rd_data;
      end
      S_USUM: begin
        ee_we = !ee_full;
        ee_wd = sum_r;
      end
      S_DFET: begin
        if (!ee_eof && exec && ee_b == `ESL_OP_IOUPD) begin
          f_valid = 1'b1;
          f_data  = {`ESL_K_IOUPD, 24'h00_0000};
        end else if (!ee_eof && exec && ee_b == `ESL_OP_CAL) begin
          f_valid = 1'b1;
          f_data  = {`ESL_K_CAL, 24'h00_0000};
        end
      end
      S_DDAT: begin
        if (!ee_eof && exec_r && wa_r != `ESL_PORT_CFG) begin
          f_valid = 1'b1;
          if (need_sync)
            f_data = {`ESL_K_SYNC, wa_r, 8'h00};
        end
      end
      default: begin
        ee_we = 1'b0;
      end
    endcase
  end

  // =====================================================================
  // Upload / download engine
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      state_r <= S_IDLE;
      sp_ptr_r <= {(`ESL_SP_AW+1){1'b0}};
      rp_r <= 12'h000;
      cnt_r <= 8'h00;
      sum_r <= 8'h00;
      ahi_r <= 8'h00;
      wa_r <= 16'h0000;
      reg_rd_addr <= 16'h0000;
      board_r <= 32'h0000_0000;
      cond_r <= 4'h0;
      exec_r <= 1'b0;
      pin_en_seen_r <= 1'b0;
      pin_armed_r <= 1'b0;
      sync_sent_r <= 1'b0;
      upload_overflow <= 1'b0;
      checksum_error <= 1'b0;
      ee_used <= 12'h000;
    end else begin
      if (ee_we)
        ee_used <= ee_used + 12'h001;
      case (state_r)
        S_IDLE: begin
          sp_ptr_r <= {(`ESL_SP_AW+1){1'b0}};
          rp_r <= 12'h000;
          board_r <= 32'h0000_0000;
          pin_en_seen_r <= 1'b0;
          pin_armed_r <= 1'b0;
          sync_sent_r <= 1'b0;
          if (upload_start) begin
            upload_overflow <= 1'b0;
            state_r <= S_UFET;
          end else if (download_start || dl_pu) begin
            cond_r <= download_start ? eff_cond
                      : pin_cond(phi_s2_r, plo_s2_r);
            checksum_error <= 1'b0;
            state_r <= S_DFET;
          end
        end
        S_UFET: begin
          if (sp_end || ee_full) begin
            upload_overflow <= ee_full;
            state_r <= S_IDLE;
          end else begin
            sp_ptr_r <= sp_ptr_r + 1'b1;
            if (sp_b < `ESL_OP_IOUPD && sp_b != `ESL_OP_CAL) begin
              cnt_r <= sp_b;
              sum_r <= sp_b;
              state_r <= S_UAH;
            end else if (sp_b == `ESL_OP_PAUSE || sp_b == `ESL_OP_END)
              state_r <= S_IDLE;
          end
        end
        S_UAH, S_UAL: begin
          if (sp_end || ee_full) begin
            upload_overflow <= ee_full;
            state_r <= S_IDLE;
          end else begin
            sp_ptr_r <= sp_ptr_r + 1'b1;
            sum_r <= sum_r + sp_b;
            ahi_r <= sp_b;
            if (state_r == S_UAL)
              reg_rd_addr <= {ahi_r, sp_b};
            state_r <= (state_r == S_UAH) ? S_UAL : S_UDAT;
          end
        end
        S_UDAT: begin
          if (ee_full) begin
            upload_overflow <= 1'b1;
            state_r <= S_IDLE;
          end else begin
            sum_r <= sum_r + ee_wd;
            reg_rd_addr <= reg_rd_addr + 16'h0001;
            cnt_r <= cnt_r - 8'h01;
            if (cnt_r == 8'h00)
              state_r <= S_USUM;
          end
        end
        S_USUM: begin
          upload_overflow <= ee_full;
          state_r <= ee_full ? S_IDLE : S_UFET;
        end
        S_DFET: begin
          if (ee_eof)
            state_r <= S_IDLE;
          else if (!(f_valid && !f_ready)) begin
            rp_r <= rp_r + 12'h001;
            if (ee_b == `ESL_OP_END)
              state_r <= S_IDLE;
            else if (ee_b == `ESL_OP_NULL)
              board_r <= 32'h0000_0000;
            else if (is_cond)
              board_r[tag_idx[4:0]] <= 1'b1;
            else if (is_data) begin
              exec_r <= exec;
              cnt_r <= ee_b;
              sum_r <= ee_b;
              state_r <= S_DAH;
            end
            if (ee_b == `ESL_OP_IOUPD && exec && pin_en_seen_r)
              pin_armed_r <= 1'b1;
          end
        end
        S_DAH, S_DAL: begin
          if (ee_eof)
            state_r <= S_IDLE;
          else begin
            rp_r <= rp_r + 12'h001;
            sum_r <= sum_r + ee_b;
            ahi_r <= ee_b;
            if (state_r == S_DAL)
              wa_r <= {ahi_r, ee_b};
            state_r <= (state_r == S_DAH) ? S_DAL : S_DDAT;
          end
        end
        S_DDAT: begin
          if (ee_eof)
            state_r <= S_IDLE;
          else if (f_valid && need_sync) begin
            if (f_ready)
              sync_sent_r <= 1'b1;
          end else if (!(f_valid && !f_ready)) begin
            if (f_valid && wa_r == `ESL_PIN_EN && ee_b == `ESL_PIN_EN_VAL)
              pin_en_seen_r <= 1'b1;
            rp_r <= rp_r + 12'h001;
            sum_r <= sum_r + ee_b;
            wa_r <= wa_r + 16'h0001;
            cnt_r <= cnt_r - 8'h01;
            if (cnt_r == 8'h00)
              state_r <= S_DSUM;
          end
        end
        S_DSUM: begin
          if (ee_eof)
            state_r <= S_IDLE;
          else begin
            rp_r <= rp_r + 12'h001;
            if (ee_b != sum_r)
              checksum_error <= 1'b1;
            state_r <= S_DFET;
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  // =====================================================================
  // Ordered write stream toward the register map; a stalled map stalls download
  esl_fifo #(
    .W (26),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .reset     (reset),
    .in_valid  (f_valid),
    .in_ready  (f_ready),
    .in_data   (f_data),
    .out_valid (cfg_wr_valid),
    .out_ready (cfg_wr_ready),
    .out_data  ({cfg_wr_kind, cfg_wr_addr, cfg_wr_data})
  );
endmodule

// ### verif/esl_loader_checker.sv
// Concurrent checks on the setup store and loader ports
`timescale 1ns/100ps
`include "esl_defines.vh"

// ====================
// Checker
module esl_loader_checker #(
  parameter FIFO_DEPTH = 4
) (
  input wire        clock,
  input wire        reset,
  input wire        upload_start,
  input wire        download_start,
  input wire        upload_busy,
  input wire        download_busy,
  input wire        cfg_wr_valid,
  input wire        cfg_wr_ready,
  input wire [1:0]  cfg_wr_kind,
  input wire [15:0] cfg_wr_addr,
  input wire [7:0]  cfg_wr_data,
  input wire [11:0] ee_used
);
  wire        idle = !upload_busy && !download_busy;
  wire [25:0] head = {cfg_wr_kind, cfg_wr_addr, cfg_wr_data};

  // An upload stores one byte per cycle, so the store size bounds its length
  logic [11:0] up_cycles_r;
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      up_cycles_r <= 12'h000;
    end else if (upload_busy) begin
      up_cycles_r <= up_cycles_r + 12'h001;
    end else begin
      up_cycles_r <= 12'h000;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  up_start_a: assert property (upload_start && idle |=> upload_busy)
    else $error("upload did not start");
  dl_start_a: assert property (download_start && !upload_start && idle |=> download_busy)
    else $error("download did not start");
  up_end_a: assert property (up_cycles_r <= 12'h834)
    else $error("upload busy stuck");
  ee_cap_a: assert property (ee_used <= `ESL_EE_BYTES)
    else $error("store pointer beyond capacity");
  ee_step_a: assert property (upload_busy |=>
    (ee_used == $past(ee_used)) || (ee_used == $past(ee_used) + 12'h001))
    else $error("more than one byte stored per cycle");
  ee_quiet_a: assert property (!upload_busy && !$past(upload_busy) |-> $stable(ee_used))
    else $error("store pointer moved outside upload");
  head_hold_a: assert property (cfg_wr_valid && !cfg_wr_ready |=>
    cfg_wr_valid && $stable(head))
    else $error("stalled entry changed");
  valid_busy_a: assert property (cfg_wr_valid |-> download_busy)
    else $error("entry pending while download busy low");
  port_cfg_a: assert property (cfg_wr_valid && cfg_wr_kind == `ESL_K_WRITE
    |-> cfg_wr_addr != `ESL_PORT_CFG)
    else $error("write to port setup register");
  sync_addr_a: assert property (cfg_wr_valid && cfg_wr_kind == `ESL_K_SYNC
    |-> cfg_wr_addr >= `ESL_PIN_F_LO && cfg_wr_addr <= `ESL_PIN_F_HI)
    else $error("sync pulse outside pin function range");
  upd_empty_a: assert property (cfg_wr_valid && (cfg_wr_kind == `ESL_K_IOUPD
    || cfg_wr_kind == `ESL_K_CAL) |-> head[23:0] == 24'h00_0000)
    else $error("command entry carries address or data");

  cover property (upload_start && idle);
  cover property (cfg_wr_valid && cfg_wr_kind == `ESL_K_SYNC);
  cover property (cfg_wr_valid && !cfg_wr_ready ##1 cfg_wr_valid);
endmodule

bind esl_loader esl_loader_checker #(.FIFO_DEPTH(FIFO_DEPTH)) u_esl_loader_checker (
  .clock(clock), .reset(reset), .upload_start(upload_start),
  .download_start(download_start), .upload_busy(upload_busy), .download_busy(download_busy),
  .cfg_wr_valid(cfg_wr_valid), .cfg_wr_ready(cfg_wr_ready), .cfg_wr_kind(cfg_wr_kind),
  .cfg_wr_addr(cfg_wr_addr), .cfg_wr_data(cfg_wr_data), .ee_used(ee_used));

// ### verif/esl_cfg_partner.sv
// Far-side model: register map reads and configuration write consumer
`timescale 1ns/100ps

// ====================
// Partner
module esl_cfg_partner (
  input  wire        clock,
  input  wire        reset,
  input  wire        stall,
  input  wire        slow,
  input  wire [15:0] reg_rd_addr,
  output wire [7:0]  reg_rd_data,
  input  wire        cfg_wr_valid,
  output wire        cfg_wr_ready,
  input  wire [1:0]  cfg_wr_kind,
  input  wire [15:0] cfg_wr_addr,
  input  wire [7:0]  cfg_wr_data
);
  logic [25:0] entry_log [$];
  logic        skip_r;

  // Port setup register is not in the map; a poison value shows any leak
  assign reg_rd_data  = (reg_rd_addr == 16'h0000) ? 8'hA5 : (reg_rd_addr[7:0] ^ 8'h01);
  // Slow mode accepts every other cycle so the FIFO sees back-pressure
  assign cfg_wr_ready = !stall && !(slow && skip_r);

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      skip_r <= 1'b0;
    end else begin
      skip_r <= !skip_r;
      if (cfg_wr_valid && cfg_wr_ready) begin
        entry_log.push_back({cfg_wr_kind, cfg_wr_addr, cfg_wr_data});
      end
    end
  end
endmodule

// ### verif/esl_loader_test.sv
// Self-checking bench for the setup store and loader
`timescale 1ns/100ps
`include "esl_defines.vh"

// ====================
// Bench
module esl_loader_test;
  logic        clock;
  logic        reset;
  logic        sp_wr_en;
  logic [15:0] sp_wr_addr;
  logic [7:0]  sp_wr_data;
  logic        upload_start;
  logic        download_start;
  logic [3:0]  cond_reg;
  logic [1:0]  pin_lo;
  logic [1:0]  pin_hi;
  logic        stall;
  logic        slow;
  wire  [15:0] reg_rd_addr;
  wire  [7:0]  reg_rd_data;
  wire         cfg_wr_valid;
  wire         cfg_wr_ready;
  wire  [1:0]  cfg_wr_kind;
  wire  [15:0] cfg_wr_addr;
  wire  [7:0]  cfg_wr_data;
  wire         upload_busy;
  wire         download_busy;
  wire         upload_overflow;
  wire         checksum_error;
  wire  [11:0] ee_used;
  wire  [3:0]  pu_cond;
  logic [25:0] expt [9];
  int          n_mismatch;
  int          checks_done;
  int          cycles;

  esl_loader #(.FIFO_DEPTH(4)) u_esl_loader (
    .clock(clock), .reset(reset), .sp_wr_en(sp_wr_en), .sp_wr_addr(sp_wr_addr),
    .sp_wr_data(sp_wr_data), .upload_start(upload_start), .download_start(download_start),
    .cond_reg(cond_reg), .cfg_select_pin_low(pin_lo), .cfg_select_pin_high(pin_hi),
    .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data), .cfg_wr_valid(cfg_wr_valid),
    .cfg_wr_ready(cfg_wr_ready), .cfg_wr_kind(cfg_wr_kind), .cfg_wr_addr(cfg_wr_addr),
    .cfg_wr_data(cfg_wr_data), .upload_busy(upload_busy), .download_busy(download_busy),
    .upload_overflow(upload_overflow), .checksum_error(checksum_error), .ee_used(ee_used),
    .powerup_condition_latch(pu_cond));

  esl_cfg_partner u_esl_cfg_partner (
    .clock(clock), .reset(reset), .stall(stall), .slow(slow), .reg_rd_addr(reg_rd_addr),
    .reg_rd_data(reg_rd_data), .cfg_wr_valid(cfg_wr_valid), .cfg_wr_ready(cfg_wr_ready),
    .cfg_wr_kind(cfg_wr_kind), .cfg_wr_addr(cfg_wr_addr), .cfg_wr_data(cfg_wr_data));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Ends on a falling edge so that results are sampled settled
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while ((upload_busy !== 1'b0 || download_busy !== 1'b0) && n < 3000);
    check("idle", 1, n < 3000);
  endtask

  task automatic do_reset(input logic [1:0] hi, input logic [1:0] lo);
    @(posedge clock);
    reset <= 1'b1;
    pin_hi <= hi;
    pin_lo <= lo;
    cond_reg <= 4'h0;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    repeat (8) @(posedge clock);
    @(negedge clock);
  endtask

  task automatic upload(input logic [7:0] seq [12], input int len, input logic [11:0] used);
    int i;
    for (i = 0; i < len; i++) begin
      @(posedge clock);
      sp_wr_en <= 1'b1;
      sp_wr_addr <= `ESL_SP_BASE + 16'(i);
      sp_wr_data <= seq[i];
    end
    @(posedge clock);
    sp_wr_en <= 1'b0;
    upload_start <= 1'b1;
    @(posedge clock);
    upload_start <= 1'b0;
    @(negedge clock);
    check("upload busy", 1, upload_busy);
    wait_idle();
    check("ee used", used, ee_used);
    check("overflow", 0, upload_overflow);
  endtask

  task automatic judge(input int first, input int n);
    int i;
    check("count", n, u_esl_cfg_partner.entry_log.size());
    for (i = 0; i < n; i++) begin
      check("entry", expt[first + i], u_esl_cfg_partner.entry_log[i]);
    end
    check("checksum", 0, checksum_error);
    u_esl_cfg_partner.entry_log.delete();
  endtask

  // Consumer stalls first so entries wait in the FIFO, which refuses once four are queued
  task automatic download(input logic [3:0] cond, input logic sl, input int first, input int n);
    @(posedge clock);
    cond_reg <= cond;
    slow <= sl;
    stall <= 1'b1;
    download_start <= 1'b1;
    @(posedge clock);
    download_start <= 1'b0;
    repeat (20) @(negedge clock);
    check("dl busy", 1, download_busy);
    check("held", n > 0, cfg_wr_valid);
    @(posedge clock);
    stall <= 1'b0;
    wait_idle();
    judge(first, n);
  endtask

  initial begin
    expt = '{26'h001_0203, 26'h100_0000, 26'h002_0001, 26'h302_0100, 26'h002_0100,
             26'h200_0000, 26'h002_0001, 26'h100_0000, 26'h002_0100};
    reset = 1'b1;
    sp_wr_en = 1'b0;
    sp_wr_addr = 16'h0000;
    sp_wr_data = 8'h00;
    upload_start = 1'b0;
    download_start = 1'b0;
    cond_reg = 4'h0;
    pin_lo = 2'h1;
    pin_hi = 2'h1;
    stall = 1'b0;
    slow = 1'b0;
    do_reset(2'h1, 2'h1);
    check("latch", 0, pu_cond);
    check("no auto", 0, download_busy);
    upload('{8'hB1, 8'h00, 8'h01, 8'h02, 8'h80, 8'hFE, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
             8'h00}, 6, 12'h008);
    upload('{8'hB0, 8'hB2, 8'h01, 8'h02, 8'h00, 8'h0A, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00,
             8'h00}, 7, 12'h012);
    download(4'h0, 1'b0, 0, 6);
    download(4'h1, 1'b1, 0, 2);
    download(4'h2, 1'b0, 2, 4);
    do_reset(2'h0, 2'h0);
    check("latch", 1, pu_cond);
    check("ee used", 0, ee_used);
    wait_idle();
    judge(0, 2);
    download(4'h0, 1'b1, 0, 2);
    download(4'h2, 1'b0, 2, 4);
    // Fresh store after reset: a dropped port-setup write, then an armed pin load
    upload('{8'hB1, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h80, 8'h00, 8'h02, 8'h01,
             8'hFF}, 12, 12'h012);
    download(4'h0, 1'b0, 6, 3);
    test_done();
  end
endmodule
